// ===== hw/tcc_pkg.sv
// Purpose: Constants for the timer and comparator control block
// Assumes: Register index times four gives the APB byte address
// Notes:   Indices, field positions, reset values and codes
package tcc_pkg;
    // ==========================================================
    // Register indices
    localparam logic [7:0] IDX_BOUND    = 8'h09;
    localparam logic [7:0] IDX_EDGE     = 8'h0C;
    localparam logic [7:0] IDX_DIG_EN   = 8'h0D;
    localparam logic [7:0] IDX_SCALER   = 8'h17;
    localparam logic [7:0] IDX_CMP_CTL  = 8'h1A;
    localparam logic [7:0] IDX_TMR_CTL  = 8'h1C;
    localparam logic [7:0] IDX_COUNT    = 8'h1D;
    localparam logic [7:0] IDX_CMP_SEL  = 8'h1E;

    // ==========================================================
    // Field positions
    localparam int CC_EN   = 7;
    localparam int CC_RES  = 6;
    localparam int CC_SAMP = 5;
    localparam int CC_INV  = 4;
    localparam int CC_MLO  = 1;
    localparam int CC_PLUS = 0;
    localparam int CS_OUT  = 7;
    localparam int CS_WAKE = 6;
    localparam int CS_HI   = 5;
    localparam int CS_LO   = 4;
    localparam int TC_CLK  = 4;
    localparam int TC_OUT  = 2;
    localparam int TC_MODE = 1;
    localparam int TC_POL  = 0;
    localparam int TS_RES  = 7;
    localparam int TS_PRE  = 5;
    localparam int ED_LO   = 6;

    // ==========================================================
    // Reset values
    localparam logic [7:0] RST_ZERO   = 8'h00;
    localparam logic [7:0] RST_DIG_EN = 8'hF9;
    localparam logic [7:0] DIG_EN_MSK = 8'hF9;

    // ==========================================================
    // Codes
    localparam logic [3:0] CLK_STOP  = 4'h0;
    localparam logic [3:0] CLK_SYS   = 4'h1;
    localparam logic [3:0] CLK_FAST  = 4'h2;
    localparam logic [3:0] CLK_SLOW  = 4'h4;
    localparam logic [3:0] CLK_CMP   = 4'h5;
    localparam logic [3:0] CLK_P0R   = 4'h8;
    localparam logic [3:0] CLK_P0F   = 4'h9;
    localparam logic [3:0] CLK_P4R   = 4'hC;
    localparam logic [3:0] CLK_P4F   = 4'hD;
    localparam logic [1:0] OUT_PIN3  = 2'h2;
    localparam logic [1:0] OUT_PIN4  = 2'h3;
    localparam logic [1:0] EDGE_BOTH = 2'h0;
    localparam logic [1:0] EDGE_RISE = 2'h1;
    localparam logic [1:0] EDGE_FALL = 2'h2;
    localparam logic [7:0] PWM6_TOP  = 8'h3F;
endpackage

// ===== hw/tcc_sync_edge.sv
// Purpose: Two-flop synchroniser with edge detection
// Assumes: Input is asynchronous to mclk
// Notes:   The first flop feeds only the second
`timescale 1ns/1ns
module tcc_sync_edge
(
    // Clock and reset
    input  wire logic mclk,
    input  wire logic arst_n,
    // Signal
    input  wire logic din,
    output logic      level,
    output logic      rise,
    output logic      fall
);
    logic meta_reg;
    logic sync_reg;
    logic prev_reg;

    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            meta_reg <= 1'b0;
            sync_reg <= 1'b0;
            prev_reg <= 1'b0;
        end
        else
        begin
            meta_reg <= din;
            sync_reg <= meta_reg;
            prev_reg <= sync_reg;
        end
    end

    assign level = sync_reg;
    assign rise  = sync_reg & ~prev_reg;
    assign fall  = ~sync_reg & prev_reg;
endmodule

// ===== hw/tcc_top.sv
// Purpose: 8-bit timer with period/PWM modes and comparator control
// Assumes: APB slave, zero wait states, analog comparator outside
// Notes:   Oscillators and pins are sampled as plain inputs
// Summary of operation
// - Comparator runs only when enable bit set
// - Result bit reads plus above minus
// - Bit 5 resamples result on timer clock
// - Bit 4 inverts comparator result output
// - Three-bit field selects comparator minus input
// - Bit 0 selects ladder or pin 4 plus
// - Select bit 7 drives comparator onto pin 0
// - Result level change wakes when enabled
// - Bits 5 and 4 pick ladder range
// - Four-bit field picks reference level
// - Four-bit field selects timer clock source
// - Two-bit field routes timer output pin
// - Control bit 1 picks period or PWM
// - Control bit 0 inverts timer output
// - Counter readable, writable, resets to zero
// - Write-only bound resets to zero
// - Scaler bit 7 picks 8 or 6-bit PWM
// - Prescaler divides by 1, 4, 16, 64
// - Write-only scaler field divides further
// - Edge field picks comparator event edges
// - Cleared digital enable makes pin analog
`timescale 1ns/1ns
module tcc_top
(
    // Clock and reset
    input  wire logic        mclk,
    input  wire logic        arst_n,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic             pready,
    output logic [31:0]      prdata,
    output logic             pslverr,
    // Clock sources
    input  wire logic        fast_internal_osc,
    input  wire logic        slow_internal_osc,
    // Port pins
    input  wire logic        port_pin_0_i,
    input  wire logic        port_pin_4_i,
    output logic             port_pin_0_o,
    output logic             port_pin_0_oe,
    output logic             port_pin_3_o,
    output logic             port_pin_3_oe,
    output logic             port_pin_4_o,
    output logic             port_pin_4_oe,
    output logic [7:0]       pin_dig_en,
    // Analog comparator
    input  wire logic        cmp_raw,
    output logic             cmp_enable,
    output logic [2:0]       cmp_minus_sel,
    output logic             cmp_plus_sel,
    output logic             cmp_range_hi,
    output logic             cmp_range_lo,
    output logic [3:0]       cmp_level,
    // Events
    output logic             wake_pulse,
    output logic             cmp_event
);
    import tcc_pkg::*;

    // ==========================================================
    // Register bus
    logic [7:0] bound_reg;
    logic [7:0] scaler_reg;
    logic [7:0] cmp_ctl_reg;
    logic [7:0] tmr_ctl_reg;
    logic [7:0] count_reg;
    logic [7:0] count_next;
    logic [7:0] cmp_sel_reg;
    logic [1:0] edge_reg;
    logic [7:0] dig_en_reg;
    logic [7:0] rd_val;
    logic       hit;
    logic       wr_en;
    logic [7:0] idx;
    logic       cmp_res;

    assign idx    = paddr[9:2];
    assign wr_en  = psel & penable & pwrite & ~pslverr;
    assign pready = 1'b1;

    always_comb
    begin
        hit    = 1'b1;
        rd_val = RST_ZERO;
        unique case (idx)
            IDX_BOUND, IDX_SCALER, IDX_CMP_SEL: rd_val = RST_ZERO;
            IDX_EDGE:    rd_val = {edge_reg, 6'h00};
            IDX_DIG_EN:  rd_val = dig_en_reg;
            IDX_CMP_CTL: rd_val = {cmp_ctl_reg[7], cmp_res, cmp_ctl_reg[5:0]};
            IDX_TMR_CTL: rd_val = tmr_ctl_reg;
            IDX_COUNT:   rd_val = count_reg;
            default:     hit = 1'b0;
        endcase
        if (paddr[11:10] != 2'h0 || paddr[1:0] != 2'h0)
            hit = 1'b0;
    end

    // Unmapped or misaligned addresses answer with an error
    assign pslverr = psel & penable & ~hit;

    // Read data is captured in the setup cycle so it comes from a flop
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
            prdata <= 32'h0000_0000;
        else if (psel & ~penable & ~pwrite)
            prdata <= {24'h00_0000, rd_val};
    end

    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            bound_reg   <= RST_ZERO;
            scaler_reg  <= RST_ZERO;
            cmp_ctl_reg <= RST_ZERO;
            tmr_ctl_reg <= RST_ZERO;
            cmp_sel_reg <= RST_ZERO;
            edge_reg    <= 2'h0;
            dig_en_reg  <= RST_DIG_EN;
        end
        else if (wr_en)
        begin
            unique case (idx)
                IDX_BOUND:   bound_reg   <= pwdata[7:0];
                IDX_SCALER:  scaler_reg  <= pwdata[7:0];
                IDX_CMP_CTL: cmp_ctl_reg <= pwdata[7:0] & 8'hBF;
                IDX_TMR_CTL: tmr_ctl_reg <= pwdata[7:0];
                IDX_CMP_SEL: cmp_sel_reg <= pwdata[7:0];
                IDX_EDGE:    edge_reg    <= pwdata[ED_LO+1:ED_LO];
                IDX_DIG_EN:  dig_en_reg  <= pwdata[7:0] & DIG_EN_MSK;
                default:     ;
            endcase
        end
    end

    // ==========================================================
    // Input sampling
    logic fast_rise;
    logic slow_rise;
    logic p0_rise;
    logic p0_fall;
    logic p4_rise;
    logic p4_fall;
    logic cmp_lvl;

    tcc_sync_edge u_fast (.mclk(mclk), .arst_n(arst_n), .din(fast_internal_osc),
                          .level(), .rise(fast_rise), .fall());
    tcc_sync_edge u_slow (.mclk(mclk), .arst_n(arst_n), .din(slow_internal_osc),
                          .level(), .rise(slow_rise), .fall());
    tcc_sync_edge u_p0   (.mclk(mclk), .arst_n(arst_n), .din(port_pin_0_i),
                          .level(), .rise(p0_rise), .fall(p0_fall));
    tcc_sync_edge u_p4   (.mclk(mclk), .arst_n(arst_n), .din(port_pin_4_i),
                          .level(), .rise(p4_rise), .fall(p4_fall));
    tcc_sync_edge u_cmp  (.mclk(mclk), .arst_n(arst_n), .din(cmp_raw),
                          .level(cmp_lvl), .rise(), .fall());

    // Disabled digital input: the pin is analog and cannot clock the timer
    assign pin_dig_en = dig_en_reg;

    // ==========================================================
    // Comparator control
    logic cmp_samp_reg;
    logic cmp_prev_reg;
    logic cmp_out;
    logic cmp_out_prev_reg;
    logic src_tick;

    assign cmp_enable    = cmp_ctl_reg[CC_EN];
    assign cmp_res       = cmp_lvl & cmp_ctl_reg[CC_EN];
    assign cmp_minus_sel = cmp_ctl_reg[CC_MLO+2:CC_MLO];
    assign cmp_plus_sel  = cmp_ctl_reg[CC_PLUS];
    assign cmp_range_hi  = cmp_sel_reg[CS_HI];
    assign cmp_range_lo  = cmp_sel_reg[CS_LO];
    assign cmp_level     = cmp_sel_reg[3:0];

    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
            cmp_samp_reg <= 1'b0;
        else if (src_tick)
            cmp_samp_reg <= cmp_res;
    end

    // Inversion is applied after sampling, so it takes effect at once
    assign cmp_out = (cmp_ctl_reg[CC_SAMP] ? cmp_samp_reg : cmp_res) ^ cmp_ctl_reg[CC_INV];

    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            cmp_prev_reg     <= 1'b0;
            cmp_out_prev_reg <= 1'b0;
            wake_pulse       <= 1'b0;
            cmp_event        <= 1'b0;
        end
        else
        begin
            cmp_prev_reg     <= cmp_res;
            cmp_out_prev_reg <= cmp_out;
            // Wake-up follows the raw result bit, not the output path
            wake_pulse <= cmp_sel_reg[CS_WAKE] & (cmp_res ^ cmp_prev_reg);
            unique case (edge_reg)
                EDGE_BOTH: cmp_event <= cmp_res ^ cmp_prev_reg;
                EDGE_RISE: cmp_event <= cmp_res & ~cmp_prev_reg;
                EDGE_FALL: cmp_event <= ~cmp_res & cmp_prev_reg;
                default:   cmp_event <= 1'b0;
            endcase
        end
    end

    assign port_pin_0_o  = cmp_out;
    assign port_pin_0_oe = cmp_sel_reg[CS_OUT];

    // ==========================================================
    // Timer clock selection and division
    logic [5:0] pre_cnt_reg;
    logic [5:0] pre_top;
    logic [4:0] scl_cnt_reg;
    logic       pre_tick;
    logic       tmr_tick;

    always_comb
    begin
        unique case (tmr_ctl_reg[TC_CLK+3:TC_CLK])
            CLK_SYS:  src_tick = 1'b1;
            CLK_FAST: src_tick = fast_rise;
            CLK_SLOW: src_tick = slow_rise;
            CLK_CMP:  src_tick = cmp_out & ~cmp_out_prev_reg;
            CLK_P0R:  src_tick = p0_rise & dig_en_reg[0];
            CLK_P0F:  src_tick = p0_fall & dig_en_reg[0];
            CLK_P4R:  src_tick = p4_rise & dig_en_reg[4];
            CLK_P4F:  src_tick = p4_fall & dig_en_reg[4];
            default:  src_tick = 1'b0;
        endcase
    end

    always_comb
    begin
        unique case (scaler_reg[TS_PRE+1:TS_PRE])
            2'h0:    pre_top = 6'h00;
            2'h1:    pre_top = 6'h03;
            2'h2:    pre_top = 6'h0F;
            default: pre_top = 6'h3F;
        endcase
    end

    assign pre_tick = src_tick && (pre_cnt_reg >= pre_top);
    assign tmr_tick = pre_tick && (scl_cnt_reg >= scaler_reg[4:0]);

    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            pre_cnt_reg <= 6'h00;
            scl_cnt_reg <= 5'h00;
        end
        else
        begin
            if (pre_tick)
                pre_cnt_reg <= 6'h00;
            else if (src_tick)
                pre_cnt_reg <= pre_cnt_reg + 6'h01;
            if (tmr_tick)
                scl_cnt_reg <= 5'h00;
            else if (pre_tick)
                scl_cnt_reg <= scl_cnt_reg + 5'h01;
        end
    end

    // ==========================================================
    // Counter and output
    logic pwm_mode;
    logic [7:0] pwm_top;
    logic per_out_reg;
    logic tmr_out;
    logic tmr_pin;
    logic cnt_wr;

    assign pwm_mode = tmr_ctl_reg[TC_MODE];
    assign pwm_top  = scaler_reg[TS_RES] ? PWM6_TOP : 8'hFF;
    assign cnt_wr   = wr_en && idx == IDX_COUNT;

    always_comb
    begin
        count_next = count_reg;
        if (tmr_tick)
        begin
            if (pwm_mode)
                count_next = (count_reg >= pwm_top) ? 8'h00 : count_reg + 8'h01;
            else
                count_next = (count_reg == bound_reg) ? 8'h00 : count_reg + 8'h01;
        end
    end

    // A software write wins over a timer tick in the same cycle
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
            count_reg <= RST_ZERO;
        else if (cnt_wr)
            count_reg <= pwdata[7:0];
        else
            count_reg <= count_next;
    end

    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
            per_out_reg <= 1'b0;
        else if (tmr_tick && !pwm_mode && count_reg == bound_reg)
            per_out_reg <= ~per_out_reg;
    end

    assign tmr_out = pwm_mode ? (count_reg < bound_reg) : per_out_reg;
    assign tmr_pin = tmr_out ^ tmr_ctl_reg[TC_POL];

    assign port_pin_3_o  = tmr_pin;
    assign port_pin_4_o  = tmr_pin;
    assign port_pin_3_oe = tmr_ctl_reg[TC_OUT+1:TC_OUT] == OUT_PIN3;
    assign port_pin_4_oe = tmr_ctl_reg[TC_OUT+1:TC_OUT] == OUT_PIN4;

    // ==========================================================
    // Assertions
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!arst_n);

    property p_cmp_off;
        psel && !penable && !pwrite && idx == IDX_CMP_CTL && !cmp_ctl_reg[CC_EN] |=> !prdata[CC_RES];
    endproperty
    a_cmp_off: assert property (p_cmp_off) else $error("result seen while disabled");

    property p_wake;
        cmp_sel_reg[CS_WAKE] && $changed(cmp_res) |=> wake_pulse;
    endproperty
    a_wake: assert property (p_wake) else $error("missing wake pulse");

    property p_no_wake;
        !cmp_sel_reg[CS_WAKE] |=> !wake_pulse;
    endproperty
    a_no_wake: assert property (p_no_wake) else $error("wake while disabled");

    property p_period_wrap;
        tmr_tick && !pwm_mode && !cnt_wr && count_reg == bound_reg
            |=> count_reg == 8'h00 && per_out_reg != $past(per_out_reg);
    endproperty
    a_period_wrap: assert property (p_period_wrap) else $error("period wrap wrong");

    property p_pwm6;
        pwm_mode && scaler_reg[TS_RES] && !cnt_wr |=> count_reg <= PWM6_TOP || $past(count_reg) > PWM6_TOP;
    endproperty
    a_pwm6: assert property (p_pwm6) else $error("6-bit count overflow");

    property p_cnt_write;
        cnt_wr |=> count_reg == $past(pwdata[7:0]);
    endproperty
    a_cnt_write: assert property (p_cnt_write) else $error("count write lost");

    property p_stopped;
        tmr_ctl_reg[TC_CLK+3:TC_CLK] == CLK_STOP && !cnt_wr |=> $stable(count_reg);
    endproperty
    a_stopped: assert property (p_stopped) else $error("count moved while stopped");

    property p_route;
        !(port_pin_3_oe && port_pin_4_oe)
            && !(tmr_ctl_reg[TC_OUT+1:TC_OUT] == 2'h1 && (port_pin_3_oe || port_pin_4_oe));
    endproperty
    a_route: assert property (p_route) else $error("timer output misrouted");

    property p_presc;
        scaler_reg[TS_PRE+1:TS_PRE] == 2'h1 && pre_cnt_reg < 6'h03 |-> !pre_tick;
    endproperty
    a_presc: assert property (p_presc) else $error("prescaler count wrong");

    property p_pin0;
        cmp_sel_reg[CS_OUT] && !cmp_ctl_reg[CC_SAMP] |-> port_pin_0_oe && port_pin_0_o == (cmp_res ^ cmp_ctl_reg[CC_INV]);
    endproperty
    a_pin0: assert property (p_pin0) else $error("pin 0 drive wrong");
endmodule

// ===== verif/tcc_far_side.sv
// Purpose: Far-side model: oscillators, port pins, comparator result
// Assumes: The bench resolves pins that the block may drive
// Notes:   Pulses are wide so the two-flop synchronisers see each level
`timescale 1ns/1ns
module tcc_far_side
(
    // Oscillators
    output logic fosc,
    output logic sosc,
    // Pins and comparator result
    output logic pin0,
    output logic pin4,
    output logic cmp_raw
);
    initial
    begin
        fosc    = 1'b0;
        sosc    = 1'b0;
        pin0    = 1'b0;
        pin4    = 1'b0;
        cmp_raw = 1'b0;
    end
    // Free running, phase unrelated to mclk
    always #13 fosc <= ~fosc;
    always #411 sosc <= ~sosc;
    // Result level for the selected plus/minus pair
    task automatic set_cmp(input logic v);
        cmp_raw <= v;
    endtask
    // n whole pulses: 0 pin 0, 1 pin 4, 2 comparator result
    task automatic pulse(input int sel, input int n);
        repeat (2 * n)
        begin
            #48;
            case (sel)
                0: pin0 <= ~pin0;
                1: pin4 <= ~pin4;
                default: cmp_raw <= ~cmp_raw;
            endcase
        end
        #48;
    endtask
endmodule

// ===== verif/timer_with_comparator_control_bench.sv
// Purpose: Self-checking bench for the timer and comparator control block
// Assumes: Zero-wait APB slave; far side modelled by tcc_far_side
// Notes:   Expected values come from the bench model, never from outputs
`timescale 1ns/1ns
module timer_with_comparator_control_bench;
    import tcc_pkg::*;
    localparam int LIMIT = 60000;
    logic        mclk = 1'b0;
    logic        arst_n = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] rd;
    logic        serr;
    logic [31:0] seed = 32'h2FDD;
    logic [7:0]  v;
    logic [3:0]  srcs [6] = '{CLK_P0R, CLK_P0F, CLK_P4R, CLK_P4F, CLK_CMP, CLK_P0R};
    logic [3:0]  oscs [4] = '{CLK_FAST, CLK_SLOW, CLK_STOP, 4'h3};
    int          pins [6] = '{0, 0, 1, 1, 2, 0};
    int          exp_evt [$] = '{2, 1, 1, 0};
    int          mdl [256];
    int          fail_count = 0;
    int          n_tests = 0;
    int          cyc = 0;
    int          n_wake = 0;
    int          n_evt = 0;
    int          g, i, b, p;
    wire [31:0]  prdata;
    wire [7:0]   dig_en;
    wire [3:0]   lvl;
    wire [2:0]   msel;
    wire         pready, pslverr, fosc, sosc, p0_far, p4_far, cmp_raw, p0_o, p0_oe, p3_o, p3_oe;
    wire         p4_o, p4_oe, cmp_en, plus_sel, rhi, rlo, wake, evt;
    wire         p0_wire = p0_oe ? p0_o : p0_far;
    wire         p4_wire = p4_oe ? p4_o : p4_far;

    always #4 mclk = ~mclk;

    tcc_top i_dut
    (
        .mclk(mclk), .arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .fast_internal_osc(fosc), .slow_internal_osc(sosc), .port_pin_0_i(p0_wire),
        .port_pin_4_i(p4_wire), .port_pin_0_o(p0_o), .port_pin_0_oe(p0_oe), .port_pin_3_o(p3_o),
        .port_pin_3_oe(p3_oe), .port_pin_4_o(p4_o), .port_pin_4_oe(p4_oe), .pin_dig_en(dig_en),
        .cmp_raw(cmp_raw), .cmp_enable(cmp_en), .cmp_minus_sel(msel), .cmp_plus_sel(plus_sel),
        .cmp_range_hi(rhi), .cmp_range_lo(rlo), .cmp_level(lvl), .wake_pulse(wake), .cmp_event(evt)
    );

    tcc_far_side i_far
    (
        .fosc(fosc), .sosc(sosc), .pin0(p0_far), .pin4(p4_far), .cmp_raw(cmp_raw)
    );

    // ==========================================================
    // Helpers
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    task automatic print_verdict();
        $display("checks %0d failures %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            fail_count++;
            $display("FAIL t=%0t got %h expected %h", $time, got, exp);
        end
    endtask

    // Called right after a rising edge; leaves one idle cycle behind
    task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] d);
        psel   <= 1'b1;
        pwrite <= wr;
        paddr  <= {2'h0, idx, 2'h0};
        pwdata <= {24'h0, d};
        @(posedge mclk);
        penable <= 1'b1;
        @(posedge mclk);
        while (pready !== 1'b1)
            @(posedge mclk);
        rd   = prdata;
        serr = pslverr;
        if (wr)
            mdl[idx] = d;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge mclk);
    endtask

    task automatic rdchk(input logic [7:0] idx, input logic [7:0] exp);
        apb(1'b0, idx, 8'h00);
        chk(rd, {24'h0, exp});
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
    endtask

    // Cycles between two toggles of the pin 3 timer output
    task automatic gap3(output int gp);
        logic l;
        @(posedge mclk);
        l = p3_o;
        repeat (2)
        begin
            gp = 0;
            while (p3_o === l && gp < 5000)
            begin
                @(posedge mclk);
                gp++;
            end
            l = p3_o;
        end
    endtask

    task automatic hi(input logic sel4, input int w, output int h);
        h = 0;
        repeat (w)
        begin
            @(posedge mclk);
            h += ((sel4 ? p4_o : p3_o) === 1'b1);
        end
    endtask

    always @(posedge mclk)
    begin
        cyc++;
        n_wake += (wake === 1'b1);
        n_evt += (evt === 1'b1);
        if (cyc == LIMIT)
        begin
            fail_count++;
            print_verdict();
        end
    end

    // ==========================================================
    // Scenarios
    initial
    begin
        repeat (16) @(posedge mclk);
        arst_n <= 1'b1;
        @(posedge mclk);
        rdchk(IDX_COUNT, 8'h00);
        rdchk(IDX_BOUND, 8'h00);
        rdchk(IDX_SCALER, 8'h00);
        rdchk(IDX_TMR_CTL, 8'h00);
        chk(32'(dig_en), 32'(RST_DIG_EN));
        apb(1'b1, IDX_COUNT, 8'hA5);
        rdchk(IDX_COUNT, 8'hA5);
        apb(1'b1, IDX_BOUND, 8'h5A);
        rdchk(IDX_BOUND, 8'h00);
        apb(1'b0, 8'h00, 8'h00);
        chk({serr, rd[30:0]}, 32'h80000000);
        v = seed[7:0];
        apb(1'b1, IDX_DIG_EN, v);
        chk(32'(dig_en), 32'(v & DIG_EN_MSK));
        apb(1'b1, IDX_DIG_EN, RST_DIG_EN);
        // Minus-input codes 0 to 5, random remaining fields
        for (i = 0; i < 6; i++)
        begin
            seed = lfsr(seed);
            v = {seed[7:4], i[2:0], seed[0]};
            apb(1'b1, IDX_CMP_CTL, v);
            rdchk(IDX_CMP_CTL, v & 8'hBF);
            chk(32'({cmp_en, msel, plus_sel}), 32'({v[7], v[3:0]}));
            apb(1'b1, IDX_CMP_SEL, seed[15:8] & 8'hBF); // Wake off: bandgap may be picked
            chk(32'({p0_oe, rhi, rlo, lvl}), 32'({seed[15], seed[13:8]}));
            rdchk(IDX_CMP_SEL, 8'h00);
        end
        // Result, sampling on the timer clock and inversion
        apb(1'b1, IDX_CMP_SEL, 8'h80);
        apb(1'b1, IDX_TMR_CTL, {CLK_SYS, 4'h0});
        apb(1'b1, IDX_CMP_CTL, 8'hA0);
        chk(32'(p0_o), 32'h0);
        apb(1'b1, IDX_TMR_CTL, {CLK_STOP, 4'h0});
        i_far.set_cmp(1'b1);
        tick(6);
        chk(32'(p0_o), 32'h0);
        rdchk(IDX_CMP_CTL, 8'hE0);
        apb(1'b1, IDX_TMR_CTL, {CLK_SYS, 4'h0});
        // The first sampling tick lands on the edge the task returns at
        tick(1);
        chk(32'(p0_o), 32'h1);
        apb(1'b1, IDX_CMP_CTL, 8'h90);
        chk(32'(p0_o), 32'h0);
        apb(1'b1, IDX_CMP_CTL, 8'h80);
        chk(32'(p0_o), 32'h1);
        apb(1'b1, IDX_CMP_CTL, 8'h00);
        rdchk(IDX_CMP_CTL, 8'h00);
        i_far.set_cmp(1'b0);
        // Minus input on the ladder, not the bandgap, with wake on and off
        apb(1'b1, IDX_CMP_CTL, 8'h86);
        for (i = 0; i < 4; i++)
        begin
            apb(1'b1, IDX_CMP_SEL, {1'b0, ~i[0], 6'h0});
            apb(1'b1, IDX_EDGE, {i[1:0], 6'h0});
            n_wake = 0;
            n_evt = 0;
            i_far.pulse(2, 1);
            tick(6);
            chk(32'(n_wake), i[0] ? 32'h0 : 32'h2);
            chk(32'(n_evt), 32'(exp_evt[i]));
        end
        // Period mode across prescaler and scaler codes
        for (i = 0; i < 4; i++)
        begin
            b = 3 * i;
            apb(1'b1, IDX_SCALER, {1'b0, i[1:0], 5'(i)});
            apb(1'b1, IDX_BOUND, 8'(b));
            apb(1'b1, IDX_COUNT, 8'h00);
            apb(1'b1, IDX_TMR_CTL, {CLK_SYS, OUT_PIN3, 2'h0});
            gap3(g);
            chk(32'(g), 32'((b + 1) * (4 ** i) * (i + 1)));
        end
        // PWM at both resolutions, both polarities, both pins
        for (i = 0; i < 4; i++)
        begin
            seed = lfsr(seed);
            p = i[0] ? 64 : 256;
            b = seed[7:0] % p;
            apb(1'b1, IDX_SCALER, {i[0], 7'h00});
            apb(1'b1, IDX_BOUND, 8'(b));
            apb(1'b1, IDX_COUNT, 8'h00);
            apb(1'b1, IDX_TMR_CTL, {CLK_SYS, i[0] ? OUT_PIN4 : OUT_PIN3, 1'b1, i[1]});
            rdchk(IDX_TMR_CTL, 8'(mdl[IDX_TMR_CTL]));
            chk(32'({p3_oe, p4_oe}), i[0] ? 32'h1 : 32'h2);
            tick(p);
            hi(i[0], p, g);
            chk(32'(g), 32'(i[1] ? p - b : b));
        end
        for (i = 0; i < 2; i++)
        begin
            apb(1'b1, IDX_TMR_CTL, {CLK_STOP, i[1:0], 2'h0});
            chk(32'({p3_oe, p4_oe}), 32'h0);
        end
        // Edge clock sources; the last run has pin 0 made analog
        apb(1'b1, IDX_BOUND, 8'hFF);
        apb(1'b1, IDX_CMP_SEL, 8'h00);
        apb(1'b1, IDX_CMP_CTL, 8'h80);
        for (i = 0; i < 6; i++)
        begin
            apb(1'b1, IDX_DIG_EN, i == 5 ? 8'hF8 : RST_DIG_EN);
            apb(1'b1, IDX_COUNT, 8'h00);
            apb(1'b1, IDX_TMR_CTL, {srcs[i], 4'h0});
            i_far.pulse(pins[i], 5);
            tick(4);
            rdchk(IDX_COUNT, i == 5 ? 8'h00 : 8'h05);
        end
        // Oscillator sources count, stopped and reserved codes hold
        for (i = 0; i < 4; i++)
        begin
            // Source first, so a late tick of the old source cannot count
            apb(1'b1, IDX_TMR_CTL, {oscs[i], 4'h0});
            apb(1'b1, IDX_COUNT, 8'h00);
            tick(300);
            apb(1'b0, IDX_COUNT, 8'h00);
            chk(32'(rd != 32'h0), 32'(i < 2));
        end
        print_verdict();
    end
endmodule
